// ==== hdl/line_coder.sv ====
`timescale 1ns/1ps
`default_nettype none
module line_coder (
  input wire logic clock,
  input wire logic rst,
  input wire logic bitTick,
  input wire logic bitVal,
  input wire logic isFraming,
  input wire logic isHeadBal,
  output line_term_pkg::line_s lineOut
);
  import line_term_pkg::*;

  logic lastPol_q;
  logic afterBal_q;
  line_s lineOut_q;

  // ************************************************************
  // Polarity choice
  // ************************************************************
  // Framing zero repeats the last polarity on purpose: that violation is what receivers lock onto
  wire keepPol = isFraming || afterBal_q;
  wire pol = keepPol ? lastPol_q : ~lastPol_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lastPol_q <= 1'b0;
      afterBal_q <= 1'b0;
      lineOut_q <= '0;
    end else if (bitTick) begin
      lineOut_q.pos <= ~bitVal & pol;
      lineOut_q.neg <= ~bitVal & ~pol;
      if (!bitVal) begin
        lastPol_q <= pol;
      end
      if (isHeadBal) begin
        afterBal_q <= 1'b1;
      end else if (!bitVal) begin
        afterBal_q <= 1'b0;
      end
    end
  end

  assign lineOut = lineOut_q;

endmodule : line_coder
`default_nettype wire

// ==== hdl/line_term_pkg.sv ====
`default_nettype none
package line_term_pkg;

  // ************************************************************
  // Line timing
  // ************************************************************
  localparam int FRAME_BITS = 48;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int BIT_PERIOD_PS = 5208333;
  localparam int BIT_DIV = BIT_PERIOD_PS / CLK_PERIOD_PS;
  localparam logic [7:0] FLAG_OCTET = 8'h7E;
  localparam logic [2:0] STUFF_AFTER_ONES = 3'h5;

  // ************************************************************
  // Bit positions, counted from zero (first bit of a frame is 0)
  // ************************************************************
  localparam logic [5:0] TX_FRAME = 6'h00;
  localparam logic [5:0] TX_BAL_HEAD = 6'h01;
  localparam logic [5:0] TX_B1_0 = 6'h02;
  localparam logic [5:0] TX_ECHO_0 = 6'h0A;
  localparam logic [5:0] TX_SIG_0 = 6'h0B;
  localparam logic [5:0] TX_ACT = 6'h0C;
  localparam logic [5:0] TX_AUXF = 6'h0D;
  localparam logic [5:0] TX_AUXN = 6'h0E;
  localparam logic [5:0] TX_B2_0 = 6'h0F;
  localparam logic [5:0] TX_ECHO_1 = 6'h17;
  localparam logic [5:0] TX_SIG_1 = 6'h18;
  localparam logic [5:0] TX_MULTI = 6'h19;
  localparam logic [5:0] TX_B1_1 = 6'h1A;
  localparam logic [5:0] TX_ECHO_2 = 6'h22;
  localparam logic [5:0] TX_SIG_2 = 6'h23;
  localparam logic [5:0] TX_SPARE = 6'h24;
  localparam logic [5:0] TX_B2_1 = 6'h25;
  localparam logic [5:0] TX_ECHO_3 = 6'h2D;
  localparam logic [5:0] TX_SIG_3 = 6'h2E;
  localparam logic [5:0] TX_BAL_TAIL = 6'h2F;
  localparam logic [5:0] LAST_BIT = 6'h2F;

  localparam logic [5:0] RX_B1_0 = 6'h02;
  localparam logic [5:0] RX_SIG_0 = 6'h0B;
  localparam logic [5:0] RX_AUXF = 6'h0D;
  localparam logic [5:0] RX_B2_0 = 6'h0F;
  localparam logic [5:0] RX_SIG_1 = 6'h18;
  localparam logic [5:0] RX_B1_1 = 6'h1A;
  localparam logic [5:0] RX_SIG_2 = 6'h23;
  localparam logic [5:0] RX_B2_1 = 6'h25;
  localparam logic [5:0] RX_SIG_3 = 6'h2E;
  localparam logic [5:0] OCTET_SPAN = 6'h07;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [3:0] {
    SL_FRAME, SL_BAL, SL_B1A, SL_B2A, SL_B1B, SL_B2B, SL_ECHO, SL_SIG,
    SL_ACT, SL_AUXF, SL_AUXN, SL_MULTI, SL_SPARE
  } slot_e;

  typedef enum logic [1:0] {H_IDLE, H_OPEN, H_DATA, H_CLOSE} hdlc_e;

  typedef struct packed {
    logic [7:0] firstBearer0;
    logic [7:0] secondBearer0;
    logic [7:0] firstBearer1;
    logic [7:0] secondBearer1;
    logic actBit;
    logic auxBit;
    logic multiBit;
    logic spareBit;
  } tx_frame_s;

  typedef struct packed {
    logic pos;
    logic neg;
  } line_s;

  typedef struct packed {
    logic [1:0] chan;
    logic [7:0] data;
  } rx_octet_s;

endpackage : line_term_pkg
`default_nettype wire

// ==== hdl/line_terminator_framer.sv ====
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Decode user frame groups in bits 1-24
// - Decode user frame groups in bits 25-48
// - Send framing, first octet, echo, signalling, aux
// - Send second octet, echo, multiframe, spare
// - Send last octet, echo, signalling, frame balance
// - One is silence, zeros alternate polarity
// - First zero after head balance repeats polarity
// - Balance bit zero when zero count odd
// - All timing from the single local clock
// - Idle signalling as ones or shared flags
// - Flag-delimited frames with zero insertion
// - Reflect received signalling bit in next echo
// - Loopback forces every echo bit zero
module line_terminator_framer #(
  parameter int BitDiv = line_term_pkg::BIT_DIV
) (
  input wire logic clock,
  input wire logic rst,
  input wire line_term_pkg::tx_frame_s txFrame,
  output logic frameLoad,
  input wire logic fillFlags,
  input wire logic echoForceZero,
  input wire logic sigValid,
  input wire logic sigBit,
  input wire logic sigLast,
  output logic sigTake,
  output line_term_pkg::line_s lineOut,
  input wire line_term_pkg::line_s lineIn,
  output logic rxLock,
  output logic rxSigValid,
  output logic rxSigBit,
  output logic rxOctetValid,
  output line_term_pkg::rx_octet_s rxOctet
);
  import line_term_pkg::*;

  localparam int DivW = $clog2(BitDiv);

  // ************************************************************
  // Slot decoding
  // ************************************************************
  function automatic logic in_octet(input logic [5:0] idx, input logic [5:0] start);
    return (idx >= start) && (idx <= start + OCTET_SPAN);
  endfunction : in_octet

  function automatic slot_e tx_kind(input logic [5:0] idx);
    slot_e k;
    k = SL_BAL;
    if (in_octet(idx, TX_B1_0)) k = SL_B1A;
    else if (in_octet(idx, TX_B2_0)) k = SL_B2A;
    else if (in_octet(idx, TX_B1_1)) k = SL_B1B;
    else if (in_octet(idx, TX_B2_1)) k = SL_B2B;
    else if (idx == TX_FRAME) k = SL_FRAME;
    else if (idx == TX_ECHO_0 || idx == TX_ECHO_1 || idx == TX_ECHO_2 || idx == TX_ECHO_3) k = SL_ECHO;
    else if (idx == TX_SIG_0 || idx == TX_SIG_1 || idx == TX_SIG_2 || idx == TX_SIG_3) k = SL_SIG;
    else if (idx == TX_ACT) k = SL_ACT;
    else if (idx == TX_AUXF) k = SL_AUXF;
    else if (idx == TX_AUXN) k = SL_AUXN;
    else if (idx == TX_MULTI) k = SL_MULTI;
    else if (idx == TX_SPARE) k = SL_SPARE;
    return k;
  endfunction : tx_kind

  function automatic slot_e rx_kind(input logic [5:0] idx);
    slot_e k;
    k = SL_BAL;
    if (in_octet(idx, RX_B1_0)) k = SL_B1A;
    else if (in_octet(idx, RX_B2_0)) k = SL_B2A;
    else if (in_octet(idx, RX_B1_1)) k = SL_B1B;
    else if (in_octet(idx, RX_B2_1)) k = SL_B2B;
    else if (idx == RX_SIG_0 || idx == RX_SIG_1 || idx == RX_SIG_2 || idx == RX_SIG_3) k = SL_SIG;
    else if (idx == RX_AUXF) k = SL_AUXF;
    else if (idx == TX_FRAME) k = SL_FRAME;
    return k;
  endfunction : rx_kind

  function automatic logic pick(input logic [7:0] oct, input logic [5:0] idx, input logic [5:0] start);
    logic [5:0] off;
    off = idx - start;
    return oct[3'h7 - off[2:0]];
  endfunction : pick

  function automatic logic tx_bit(input slot_e k, input tx_frame_s f, input logic [5:0] idx,
                                  input logic sig, input logic echo, input logic bal);
    logic b;
    case (k)
      SL_FRAME: b = 1'b0;
      SL_BAL: b = bal;
      SL_B1A: b = pick(f.firstBearer0, idx, TX_B1_0);
      SL_B2A: b = pick(f.secondBearer0, idx, TX_B2_0);
      SL_B1B: b = pick(f.firstBearer1, idx, TX_B1_1);
      SL_B2B: b = pick(f.secondBearer1, idx, TX_B2_1);
      SL_ECHO: b = echo;
      SL_SIG: b = sig;
      SL_ACT: b = f.actBit;
      SL_AUXF: b = f.auxBit;
      SL_AUXN: b = ~f.auxBit;
      SL_MULTI: b = f.multiBit;
      SL_SPARE: b = f.spareBit;
      default: b = 1'b1;
    endcase
    return b;
  endfunction : tx_bit

  // ************************************************************
  // Bit divider and transmit position
  // ************************************************************
  logic [DivW-1:0] divCnt_q;
  logic [5:0] txIdx_q;
  tx_frame_s curFrame_q;
  logic frameLoad_q;
  logic parity_q;
  logic echo_q;

  wire bitTick = divCnt_q == DivW'(BitDiv - 1);
  wire frameHead = txIdx_q == TX_FRAME;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      divCnt_q <= '0;
      txIdx_q <= TX_FRAME;
      curFrame_q <= '0;
      frameLoad_q <= 1'b0;
    end else begin
      divCnt_q <= bitTick ? '0 : divCnt_q + 1'b1;
      frameLoad_q <= bitTick && frameHead;
      if (bitTick) begin
        txIdx_q <= (txIdx_q == LAST_BIT) ? TX_FRAME : txIdx_q + 6'h01;
        if (frameHead) curFrame_q <= txFrame;
      end
    end
  end

  // ************************************************************
  // Transmit bit selection
  // ************************************************************
  slot_e txKind;
  logic sigOut;
  assign txKind = tx_kind(txIdx_q);
  wire echoOut = echoForceZero ? 1'b0 : echo_q;
  wire balOut = ~parity_q;
  wire txBit = tx_bit(txKind, curFrame_q, txIdx_q, sigOut, echoOut, balOut);
  wire sigSlotTick = bitTick && txKind == SL_SIG;

  // Parity of zeros since the previous balance bit
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      parity_q <= 1'b0;
    end else if (bitTick) begin
      if (txKind == SL_BAL) parity_q <= 1'b0;
      else if (!txBit) parity_q <= ~parity_q;
    end
  end

  line_coder coder (
    .clock(clock),
    .rst(rst),
    .bitTick(bitTick),
    .bitVal(txBit),
    .isFraming(txKind == SL_FRAME),
    .isHeadBal(txIdx_q == TX_BAL_HEAD),
    .lineOut(lineOut)
  );

  // ************************************************************
  // Signalling channel framing
  // ************************************************************
  hdlc_e hdlc_q, hdlc_d;
  logic [2:0] flagCnt_q, flagCnt_d;
  logic [2:0] ones_q, ones_d;
  logic take_d;
  logic sigTake_q;
  wire flagBit = FLAG_OCTET[3'h7 - flagCnt_q];
  wire stuffDue = ones_q == STUFF_AFTER_ONES && flagCnt_q == 3'h0;
  wire flagEnd = flagCnt_q == 3'h7;

  always_comb begin
    hdlc_d = hdlc_q;
    flagCnt_d = flagCnt_q;
    ones_d = ones_q;
    take_d = 1'b0;
    sigOut = 1'b1;
    case (hdlc_q)
      H_IDLE: begin
        sigOut = fillFlags ? flagBit : 1'b1;
        flagCnt_d = fillFlags ? flagCnt_q + 3'h1 : 3'h0;
        if (sigValid && !fillFlags) begin
          hdlc_d = H_OPEN;
        end else if (sigValid && flagEnd) begin
          // Idle flag just sent doubles as the opening flag
          hdlc_d = H_DATA;
          ones_d = 3'h0;
        end
      end
      H_OPEN: begin
        sigOut = flagBit;
        flagCnt_d = flagCnt_q + 3'h1;
        ones_d = 3'h0;
        if (flagEnd) hdlc_d = H_DATA;
      end
      H_DATA: begin
        if (stuffDue) begin
          sigOut = 1'b0;
          ones_d = 3'h0;
        end else if (sigValid) begin
          sigOut = sigBit;
          take_d = 1'b1;
          ones_d = sigBit ? ones_q + 3'h1 : 3'h0;
          if (sigLast) hdlc_d = H_CLOSE;
        end else begin
          // Underrun closes the frame early rather than sending garbage
          sigOut = flagBit;
          flagCnt_d = flagCnt_q + 3'h1;
          hdlc_d = H_CLOSE;
        end
      end
      H_CLOSE: begin
        if (stuffDue) begin
          sigOut = 1'b0;
          ones_d = 3'h0;
        end else begin
          sigOut = flagBit;
          flagCnt_d = flagCnt_q + 3'h1;
          ones_d = 3'h0;
          if (flagEnd) hdlc_d = sigValid ? H_DATA : H_IDLE;
        end
      end
      default: hdlc_d = H_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hdlc_q <= H_IDLE;
      flagCnt_q <= 3'h0;
      ones_q <= 3'h0;
      sigTake_q <= 1'b0;
    end else begin
      sigTake_q <= sigSlotTick && take_d;
      if (sigSlotTick) begin
        hdlc_q <= hdlc_d;
        flagCnt_q <= flagCnt_d;
        ones_q <= ones_d;
      end
    end
  end

  // ************************************************************
  // Receive alignment and extraction
  // ************************************************************
  logic [5:0] rxIdx_q;
  logic rxLock_q, rxCand_q, rxSeen_q, rxLastPol_q;
  logic rxAfterBal_q;
  logic [7:0] rxShift_q;
  logic rxSigValid_q, rxSigBit_q, rxOctetValid_q;
  rx_octet_s rxOctet_q;
  slot_e rxKind;

  wire rxPulse = lineIn.pos | lineIn.neg;
  wire rxBit = ~rxPulse;
  wire violation = rxPulse && rxSeen_q && lineIn.pos == rxLastPol_q;
  wire rxHead = rxIdx_q == TX_FRAME;
  wire rxAligned = rxLock_q || rxCand_q;
  // The first zero after the head balance also repeats polarity; any other violation means we sit on the wrong bit
  wire misplaced = rxAligned && violation && !rxHead && !rxAfterBal_q;
  assign rxKind = rx_kind(rxIdx_q);
  wire rxOctetEnd = (rxKind == SL_B1A || rxKind == SL_B2A || rxKind == SL_B1B || rxKind == SL_B2B)
                    && rx_kind(rxIdx_q + 6'h01) == SL_BAL;
  wire [1:0] rxChan = (rxKind == SL_B1A) ? 2'h0 : (rxKind == SL_B2A) ? 2'h1 : (rxKind == SL_B1B) ? 2'h2 : 2'h3;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rxIdx_q <= TX_FRAME;
      rxLock_q <= 1'b0;
      rxCand_q <= 1'b0;
      rxSeen_q <= 1'b0;
      rxLastPol_q <= 1'b0;
      rxAfterBal_q <= 1'b0;
      rxShift_q <= 8'h00;
      rxSigValid_q <= 1'b0;
      rxSigBit_q <= 1'b1;
      rxOctetValid_q <= 1'b0;
      rxOctet_q <= '0;
      echo_q <= 1'b1;
    end else begin
      rxSigValid_q <= 1'b0;
      rxOctetValid_q <= 1'b0;
      if (bitTick) begin
        if (rxPulse) begin
          rxSeen_q <= 1'b1;
          rxLastPol_q <= lineIn.pos;
        end
        rxIdx_q <= (rxIdx_q == LAST_BIT) ? TX_FRAME : rxIdx_q + 6'h01;
        if (rxIdx_q == TX_BAL_HEAD) begin
          rxAfterBal_q <= 1'b1;
        end else if (rxPulse) begin
          rxAfterBal_q <= 1'b0;
        end
        if (rxAligned && rxHead) begin
          rxLock_q <= violation;
          rxCand_q <= 1'b0;
        end else if (violation && (!rxAligned || misplaced)) begin
          rxLock_q <= 1'b0;
          rxCand_q <= 1'b1;
          rxIdx_q <= TX_BAL_HEAD;
        end
        if (rxLock_q && rxKind == SL_SIG) begin
          echo_q <= rxBit;
          rxSigBit_q <= rxBit;
          rxSigValid_q <= 1'b1;
        end
        if (rxLock_q && rxKind >= SL_B1A && rxKind <= SL_B2B) begin
          rxShift_q <= {rxShift_q[6:0], rxBit};
          if (rxOctetEnd) begin
            rxOctet_q.data <= {rxShift_q[6:0], rxBit};
            rxOctet_q.chan <= rxChan;
            rxOctetValid_q <= 1'b1;
          end
        end
      end
    end
  end

  assign frameLoad = frameLoad_q;
  assign sigTake = sigTake_q;
  assign rxLock = rxLock_q;
  assign rxSigValid = rxSigValid_q;
  assign rxSigBit = rxSigBit_q;
  assign rxOctetValid = rxOctetValid_q;
  assign rxOctet = rxOctet_q;

endmodule : line_terminator_framer
`default_nettype wire

// ==== tb/basic_access_frame_line_coder_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module basic_access_frame_line_coder_tb;
  import line_term_pkg::*;
  localparam int BitDiv = 4;
  logic clock = 1'h0;
  logic rst = 1'h1;
  tx_frame_s txFrame = '0;
  logic fillFlags = 1'h0;
  logic echoForceZero = 1'h0;
  logic sigValid = 1'h0;
  logic sigBit = 1'h0;
  logic sigLast = 1'h0;
  logic frameLoad, sigTake, rxLock, rxSigValid, rxSigBit, rxOctetValid, mayStart;
  line_s lineOut, lineIn;
  rx_octet_s rxOctet;
  logic [31:0] octets = 32'h96C33CA5;
  logic [3:0] dBits = 4'h6;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  line_terminator_framer #(.BitDiv(BitDiv)) line_terminator_framer_i (
    .clock(clock), .rst(rst), .txFrame(txFrame), .frameLoad(frameLoad), .fillFlags(fillFlags),
    .echoForceZero(echoForceZero), .sigValid(sigValid), .sigBit(sigBit), .sigLast(sigLast),
    .sigTake(sigTake), .lineOut(lineOut), .lineIn(lineIn), .rxLock(rxLock), .rxSigValid(rxSigValid),
    .rxSigBit(rxSigBit), .rxOctetValid(rxOctetValid), .rxOctet(rxOctet));
  user_station_model #(.BitDiv(BitDiv)) user_station_model_i (
    .clock(clock), .rst(rst), .frameLoad(frameLoad), .octets(octets), .dBits(dBits), .lineOut(lineOut),
    .lineIn(lineIn), .mayStart(mayStart));
  always #2.5 clock = ~clock;
  // ****
  // Shared helpers
  // ****
  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  always @(posedge clock) begin
    cycles++;
    if (cycles > 20000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'h1) begin
      miscompares++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : check
  function automatic logic [7:0] oct(input logic [47:0] fr, input int at);
    for (int j = 0; j < 8; j++) oct[7 - j] = fr[at + j];
  endfunction : oct
  // Ends on bit 47 so that a following call catches the next head
  task automatic grab(output logic [47:0] fr);
    int n;
    n = 0;
    @(posedge clock);
    #1;
    while (frameLoad !== 1'h1 && n < 400) begin
      @(posedge clock);
      #1;
      n++;
    end
    check(n < 400, "no frame head");
    for (int i = 0; i < 48; i++) begin
      fr[i] = lineOut === 2'h0;
      if (i < 47) repeat (BitDiv) @(posedge clock);
      #1;
    end
  endtask : grab
  task automatic dstream(input int nf, output logic [31:0] s);
    logic [47:0] fr;
    s = '1;
    repeat (nf) begin
      grab(fr);
      s = {s[27:0], fr[11], fr[24], fr[35], fr[46]};
    end
  endtask : dstream
  // ****
  // Scenarios
  // ****
  task automatic t_reset();
    check(lineOut === 2'h0 && frameLoad === 1'h0, "line in reset");
    check(rxLock === 1'h0 && rxSigBit === 1'h1, "receiver in reset");
  endtask : t_reset
  task automatic t_layout();
    logic [47:0] f;
    tx_frame_s t;
    t = '{8'h96, 8'h3C, 8'hE1, 8'h5A, 1'h1, 1'h0, 1'h1, 1'h0};
    @(posedge clock);
    txFrame <= t;
    grab(f);
    grab(f);
    check(f[1:0] === 2'h0, "framing pair");
    check(oct(f, 2) === t.firstBearer0 && oct(f, 15) === t.secondBearer0, "first octets");
    check(oct(f, 26) === t.firstBearer1 && oct(f, 37) === t.secondBearer1, "second octets");
    check(f[14:12] === {!t.auxBit, t.auxBit, t.actBit}, "act and aux");
    check(f[25] === t.multiBit && f[36] === t.spareBit, "multiframe and spare");
    check({f[11], f[24], f[35], f[46]} === 4'hF, "idle ones");
    check(f[47] === ~^(~f[46:2]), "frame balance");
  endtask : t_layout
  task automatic t_rx();
    int n;
    int seen;
    logic [1:0] ch;
    n = 0;
    seen = 0;
    ch = 2'h0;
    while (n < 800 && seen < 12) begin
      @(posedge clock);
      #1;
      n++;
      if (rxOctetValid === 1'h1) begin
        ch = rxOctet.chan;
        seen++;
        check(rxLock === 1'h1 && rxOctet.data === octets[8 * (3 - ch) +: 8], "bearer octet");
      end
      if (rxSigValid === 1'h1 && seen > 0) begin
        seen++;
        check(rxSigBit === dBits[ch], "signalling bit");
      end
    end
    check(seen >= 12, "receive stalled");
  endtask : t_rx
  task automatic t_echo();
    logic [47:0] f;
    grab(f);
    check({f[10], f[23], f[34], f[45]} === {dBits[3], dBits[0], dBits[1], dBits[2]}, "echo copy");
  endtask : t_echo
  task automatic t_force();
    logic [47:0] f;
    @(posedge clock);
    dBits <= 4'hF;
    echoForceZero <= 1'h1;
    grab(f);
    grab(f);
    check({f[10], f[23], f[34], f[45]} === 4'h0, "forced echo");
    check(mayStart === 1'h0, "count not restarted");
    @(posedge clock);
    echoForceZero <= 1'h0;
    grab(f);
    grab(f);
    check({f[10], f[23], f[34], f[45]} === 4'hF, "echo released");
  endtask : t_force
  // Five ones in the payload force one inserted zero
  task automatic t_sig();
    logic [31:0] s;
    logic [7:0] pay;
    int n;
    int p;
    pay = 8'hFA;
    n = 0;
    fork
      begin
        do @(posedge clock); while (frameLoad !== 1'h1);
        for (int i = 7; i >= 0; i--) begin
          sigValid <= 1'h1;
          sigBit <= pay[i];
          sigLast <= (i == 0);
          do begin
            @(posedge clock);
            n++;
          end while (sigTake !== 1'h1 && n < 4000);
        end
        sigValid <= 1'h0;
        sigLast <= 1'h0;
      end
      dstream(8, s);
    join
    p = 31;
    while (p > 24 && s[p] !== 1'h0) p--;
    check(n < 4000, "payload not taken");
    check(mayStart === 1'h1, "start threshold not reached");
    check(s[p -: 25] === 25'h0FDF27E, "flagged stuffed frame");
  endtask : t_sig
  task automatic t_flags();
    logic [31:0] s;
    int hit;
    @(posedge clock);
    fillFlags <= 1'h1;
    dstream(2, s);
    dstream(6, s);
    hit = 0;
    for (int p = 31; p >= 15; p--) if (s[p -: 8] === FLAG_OCTET && s[p - 8 -: 8] === FLAG_OCTET) hit++;
    check(hit > 0, "flag fill");
  endtask : t_flags
  initial begin
    repeat (8) @(posedge clock);
    t_reset();
    rst <= 1'h0;
    t_layout();
    t_rx();
    t_echo();
    t_force();
    t_sig();
    t_flags();
    close_out();
  end
endmodule : basic_access_frame_line_coder_tb
`default_nettype wire

// ==== tb/line_terminator_framer_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module line_terminator_framer_checker #(
  parameter int BitDiv = line_term_pkg::BIT_DIV
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic frameLoad,
  input wire logic echoForceZero,
  input wire line_term_pkg::line_s lineOut
);
  import line_term_pkg::*;
  // ****
  // Bit position tracker locked to frameLoad
  // ****
  logic [15:0] phase_q;
  logic [5:0] idx_q;
  logic [17:0] clk_q;
  logic sync_q, lastPos_q, afterBal_q, zeroOdd_q;
  wire wrap = phase_q == 16'(BitDiv - 1);
  wire bitStart = frameLoad || (sync_q && phase_q == 16'h0);
  wire [5:0] curIdx = frameLoad ? 6'h00 : idx_q;
  wire pulse = lineOut != 2'h0;
  wire isEcho = curIdx inside {6'h0A, 6'h17, 6'h22, 6'h2D};
  // Polarity memory sees every pulse, including the framing pair
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      phase_q <= 16'h0;
      idx_q <= 6'h00;
      clk_q <= 18'h0;
      sync_q <= 1'h0;
      lastPos_q <= 1'h0;
      afterBal_q <= 1'h0;
      zeroOdd_q <= 1'h0;
    end else begin
      phase_q <= frameLoad ? 16'h1 : (wrap ? 16'h0 : phase_q + 16'h1);
      idx_q <= frameLoad ? 6'h00 : idx_q + 6'(wrap);
      clk_q <= frameLoad ? 18'h1 : clk_q + 18'h1;
      sync_q <= sync_q | frameLoad;
      if (bitStart && pulse) lastPos_q <= lineOut.pos;
      if (bitStart && curIdx == 6'h01) begin
        afterBal_q <= 1'h1;
        zeroOdd_q <= 1'h0;
      end else if (bitStart && pulse && curIdx > 6'h01) begin
        afterBal_q <= 1'h0;
        zeroOdd_q <= !zeroOdd_q;
      end
    end
  end
  // ****
  // Properties
  // ****
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  no_double_pulse_a: assert property (!(lineOut.pos && lineOut.neg))
    else $error("both polarities driven");
  bit_stands_a: assert property (sync_q && !bitStart |-> $stable(lineOut))
    else $error("line changed inside a bit");
  frame_period_a: assert property (frameLoad && sync_q |-> clk_q == 18'(48 * BitDiv))
    else $error("frame period wrong");
  head_violation_a: assert property (frameLoad |-> pulse && lineOut.pos == lastPos_q)
    else $error("framing bit is not a violation");
  head_balance_a: assert property (bitStart && curIdx == 6'h01 |-> pulse && lineOut.pos != lastPos_q)
    else $error("head balance wrong");
  zero_alternate_a: assert property (bitStart && curIdx > 6'h01 && pulse |->
    (lineOut.pos == lastPos_q) == afterBal_q) else $error("zero polarity wrong");
  frame_balance_a: assert property (bitStart && curIdx == 6'h2F |-> pulse == zeroOdd_q)
    else $error("frame balance wrong");
  echo_forced_a: assert property (bitStart && isEcho && $past(echoForceZero) && echoForceZero |-> pulse)
    else $error("echo not forced to zero");
endmodule : line_terminator_framer_checker
bind line_terminator_framer line_terminator_framer_checker #(.BitDiv(BitDiv)) line_terminator_framer_checker_i (
  .clock(clock),
  .rst(rst),
  .frameLoad(frameLoad),
  .echoForceZero(echoForceZero),
  .lineOut(lineOut)
);
`default_nettype wire

// ==== tb/user_station_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Frame start comes from frameLoad, standing in for recovery from the line
module user_station_model #(
  parameter int BitDiv = 4,
  parameter bit SigClass = 1'b1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic frameLoad,
  input wire logic [31:0] octets,
  input wire logic [3:0] dBits,
  input wire line_term_pkg::line_s lineOut,
  output line_term_pkg::line_s lineIn,
  output logic mayStart
);
  import line_term_pkg::*;
  // ****
  // Frame image with per-group balance
  // ****
  function automatic logic [47:0] build(input logic [31:0] o, input logic [3:0] d);
    logic [47:0] v;
    int zc;
    v = '1;
    zc = 0;
    v[0] = 1'h0;
    v[13] = 1'h0;
    v[11] = d[0];
    v[24] = d[1];
    v[35] = d[2];
    v[46] = d[3];
    for (int j = 0; j < 8; j++) begin
      v[2 + j] = o[31 - j];
      v[15 + j] = o[23 - j];
      v[26 + j] = o[15 - j];
      v[37 + j] = o[7 - j];
    end
    for (int k = 0; k < 48; k++) begin
      if (k inside {1, 10, 12, 14, 23, 25, 34, 36, 45, 47}) begin
        v[k] = !zc[0];
        zc = 0;
      end else begin
        zc += v[k] ? 0 : 1;
      end
    end
    return v;
  endfunction : build
  // ****
  // Transmit timing, two bits behind the received frame
  // ****
  logic [15:0] pos_q;
  logic [47:0] frame_q;
  logic run_q, lastPos_q, afterBal_q;
  wire [15:0] slot = pos_q / 16'(BitDiv);
  wire [5:0] u = 6'((slot + 16'h2E) % 16'h30);
  wire boundary = run_q && (pos_q % 16'(BitDiv)) == 16'h0;
  wire [47:0] img = (u == 6'h00) ? build(octets, dBits) : frame_q;
  wire pol = (u == 6'h00 || afterBal_q) ? lastPos_q : !lastPos_q;
  // Echo watch: sampled one clock into each echo bit of the received frame
  logic [3:0] ones_q;
  logic lower_q, lastD_q;
  wire echoAt = run_q && pos_q % 16'(BitDiv) == 16'h1 && slot inside {16'd10, 16'd23, 16'd34, 16'd45};
  wire echoOne = lineOut == 2'h0;
  wire [3:0] thresh = (SigClass ? 4'h8 : 4'hA) + {3'h0, lower_q};
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pos_q <= 16'h0;
      frame_q <= '1;
      run_q <= 1'h0;
      lastPos_q <= 1'h0;
      afterBal_q <= 1'h0;
      lineIn <= '0;
      ones_q <= 4'h0;
      lower_q <= 1'h0;
      lastD_q <= 1'h1;
      mayStart <= 1'h0;
    end else begin
      if (echoAt) begin
        ones_q <= !echoOne ? 4'h0 : (ones_q == 4'hB ? ones_q : ones_q + 4'h1);
        mayStart <= echoOne && ones_q >= thresh && echoOne == lastD_q;
        if (lower_q && ones_q == thresh) lower_q <= 1'h0;
        else if (mayStart) lower_q <= 1'h1;
      end
      pos_q <= frameLoad ? 16'h1 : (pos_q == 16'(48 * BitDiv - 1) ? 16'h0 : pos_q + 16'h1);
      run_q <= run_q | frameLoad;
      if (boundary) begin
        frame_q <= img;
        if (u inside {6'd11, 6'd24, 6'd35, 6'd46}) lastD_q <= img[u];
        lineIn <= img[u] ? 2'h0 : {pol, !pol};
        if (!img[u]) begin
          lastPos_q <= pol;
          afterBal_q <= (u == 6'h01);
        end
      end
    end
  end
endmodule : user_station_model
`default_nettype wire
